/* File: lrp_consts.svh */
// timing counts, depths and reset values of the record and playback port pair
// Functional notes
// - record port latches word on each valid edge
// - source drives sixteen bits, clock and valid
// - record port drives hold-off back to source
// - hold-off rises sixteen source clocks before overflow
// - source drops valid within the warning window
// - playback drives sixteen bits, clock and valid
// - playback samples receiver hold-off input
// - playback data stable at outgoing rising edge
// - words kept in arrival order, no framing
// - separate input link and output link
// - record bits 0 to 15, 15 is MSB
// - playback bits 0 to 15, 0 is LSB
// - flow control off until software enables it
// - record needs receive mode, playback transmit mode
// - playback clock programmable, defaults to 200 MHz; the divider gives 50 MHz from the 100 MHz system clock
// - playback clock chosen from predefined frequency set
`ifndef LRP_CONSTS_SVH
`define LRP_CONSTS_SVH
`define LRP_DATA_W 16
`define LRP_REC_DEPTH 32
`define LRP_WARN_CLKS 16
`define LRP_WARN_SLACK 4
`define LRP_SYS_KHZ 100000
`define LRP_F20_KHZ 20000
`define LRP_F31_KHZ 31250
`define LRP_F62_KHZ 62500
`define LRP_F95_KHZ 95000
`define LRP_F100_KHZ 100000
`define LRP_F125_KHZ 125000
`define LRP_F150_KHZ 150000
`define LRP_F160_KHZ 160000
`define LRP_F190_KHZ 190000
`define LRP_F200_KHZ 200000
`define LRP_FC_RESET 1'b0
`define LRP_PLAY_CLK_RESET clk_sel_200
`define LRP_REC_HALF 4
`define LRP_SINK_DEPTH 16
`define LRP_SINK_HOLD 8
`endif

/* File: lrp_pkg.sv */
// types and clock divider lookup used by the device end of the port pair
`include "lrp_consts.svh"
package lrp_pkg;
   typedef enum logic [1:0] {mode_idle, receive_mode, transmit_mode} lrp_mode_t;

   typedef enum logic [3:0] {
      clk_sel_20, clk_sel_31_25, clk_sel_62_5, clk_sel_95, clk_sel_100,
      clk_sel_125, clk_sel_150, clk_sel_160, clk_sel_190, clk_sel_200
   } lrp_clk_sel_t;

   // half period in system cycles, rounded up so the clock never runs fast
   function automatic logic [7:0] lrp_half(input int unsigned f_khz);
      int unsigned h;
      h = (`LRP_SYS_KHZ + 2 * f_khz - 1) / (2 * f_khz);
      return (h == 0) ? 8'h01 : 8'(h);
   endfunction

   // half period of the playback clock for a frequency choice
   function automatic logic [7:0] lrp_play_half(input lrp_clk_sel_t sel);
      case (sel)
         clk_sel_20: return lrp_half(`LRP_F20_KHZ);
         clk_sel_31_25: return lrp_half(`LRP_F31_KHZ);
         clk_sel_62_5: return lrp_half(`LRP_F62_KHZ);
         clk_sel_95: return lrp_half(`LRP_F95_KHZ);
         clk_sel_100: return lrp_half(`LRP_F100_KHZ);
         clk_sel_125: return lrp_half(`LRP_F125_KHZ);
         clk_sel_150: return lrp_half(`LRP_F150_KHZ);
         clk_sel_160: return lrp_half(`LRP_F160_KHZ);
         clk_sel_190: return lrp_half(`LRP_F190_KHZ);
         default: return lrp_half(`LRP_F200_KHZ);
      endcase
   endfunction
endpackage

/* File: lrp_if.sv */
// link wires between the device end and the far end
`timescale 1ns/1ps
`default_nettype none
`include "lrp_consts.svh"
interface lrp_if;
   logic rec_clk;
   logic [`LRP_DATA_W-1:0] rec_data;
   logic rec_word_valid;
   logic rec_hold_off;
   logic play_clk;
   logic [`LRP_DATA_W-1:0] play_data;
   logic play_word_valid;
   logic play_hold_off;

   modport dev (
      input rec_clk, rec_data, rec_word_valid,
      output rec_hold_off,
      output play_clk, play_data, play_word_valid,
      input play_hold_off
   );

   modport far (
      output rec_clk, rec_data, rec_word_valid,
      input rec_hold_off,
      input play_clk, play_data, play_word_valid,
      output play_hold_off
   );
endinterface
`default_nettype wire

/* File: lrp_dev.sv */
// device end: record link into storage out to the user side, user side onto playback link
`timescale 1ns/1ps
`default_nettype none
`include "lrp_consts.svh"
module lrp_dev #(
   parameter int REC_DEPTH = `LRP_REC_DEPTH,
   parameter int WARN_CLKS = `LRP_WARN_CLKS,
   parameter int WARN_SLACK = `LRP_WARN_SLACK
) (
   input wire logic clk_sys,
   input wire logic reset,
   lrp_if.dev link,
   input wire logic cfg_load,
   input wire lrp_pkg::lrp_mode_t cfg_mode,
   input wire logic cfg_flow_control_enable,
   input wire lrp_pkg::lrp_clk_sel_t cfg_play_clock_select,
   output logic [`LRP_DATA_W-1:0] rec_out_data,
   output logic rec_out_valid,
   input wire logic rec_out_ready,
   input wire logic [`LRP_DATA_W-1:0] play_in_data,
   input wire logic play_in_valid,
   output logic play_in_ready,
   output lrp_pkg::lrp_mode_t mode_status,
   output logic flow_control_status
);
   import lrp_pkg::*;

   localparam int DW = `LRP_DATA_W;
   localparam int AW = $clog2(REC_DEPTH);

   // the warning window must fit in a power-of-two buffer
   if (REC_DEPTH != (1 << AW) || REC_DEPTH <= WARN_CLKS + WARN_SLACK) begin : g_bad_depth
      $error("record buffer depth cannot hold the hold-off warning window");
   end

   typedef logic [AW:0] lrp_ptr_t;

   localparam lrp_ptr_t HOLD_LEVEL = lrp_ptr_t'(REC_DEPTH - WARN_CLKS - WARN_SLACK);

   // state clocked by the source's record clock
   typedef struct packed {
      logic [REC_DEPTH-1:0][DW-1:0] mem;
      lrp_ptr_t wbin;
      lrp_ptr_t wgray;
      lrp_ptr_t rg1;
      lrp_ptr_t rg2;
      logic [2:0] rx_s;
      logic [2:0] fc_s;
      logic rx_q;
      logic fc_q;
      logic rs1;
      logic rs2;
      logic hold_off;
   } lrp_rec_st_t;

   // state clocked by the system clock
   typedef struct packed {
      lrp_mode_t mode_r;
      logic fc_r;
      lrp_clk_sel_t sel_r;
      logic rx_on;
      lrp_ptr_t rbin;
      lrp_ptr_t rgray;
      lrp_ptr_t wg1;
      lrp_ptr_t wg2;
      logic out_v;
      logic [DW-1:0] out_d;
      logic [1:0][DW-1:0] pbuf;
      logic pwr;
      logic prd;
      logic [1:0] pcnt;
      logic in_ready;
      logic [2:0] hs;
      logic hold_q;
      logic [7:0] div;
      logic pclk;
      logic rst_seen;
      logic [DW-1:0] pd;
      logic pv;
   } lrp_sys_st_t;

   lrp_rec_st_t rr;
   lrp_rec_st_t rn;
   lrp_sys_st_t sr;
   lrp_sys_st_t sn;
   lrp_ptr_t rec_fill;
   logic fall;
   logic push;
   logic pop;

   function automatic lrp_ptr_t gray_of(input lrp_ptr_t b);
      return b ^ (b >> 1);
   endfunction

   function automatic lrp_ptr_t bin_of(input lrp_ptr_t g);
      lrp_ptr_t b;
      b = g;
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction

   // record link side: capture, buffer fill and hold-off warning
   always_comb begin
      rn = rr;
      rn.rs1 = reset;
      rn.rs2 = rr.rs1;
      rn.rg1 = sr.rgray;
      rn.rg2 = rr.rg1;
      rn.rx_s = {rr.rx_s[1:0], sr.rx_on};
      rn.fc_s = {rr.fc_s[1:0], sr.fc_r};
      if (rr.rx_s[1] == rr.rx_s[2]) begin
         rn.rx_q = rr.rx_s[2];
      end
      if (rr.fc_s[1] == rr.fc_s[2]) begin
         rn.fc_q = rr.fc_s[2];
      end
      rec_fill = rr.wbin - bin_of(rr.rg2);
      // only valid edges in receive mode store a word
      if (link.rec_word_valid && rr.rx_q && !rec_fill[AW]) begin
         rn.mem[rr.wbin[AW-1:0]] = link.rec_data;
         rn.wbin = rr.wbin + 1'b1;
      end
      rn.wgray = gray_of(rn.wbin);
      rec_fill = rn.wbin - bin_of(rr.rg2);
      // fill is seen pessimistically, so the warning is never late
      rn.hold_off = rr.fc_q && (!rr.rx_q || rec_fill >= HOLD_LEVEL);
      if (rr.rs2) begin
         rn.wbin = '0;
         rn.wgray = '0;
         rn.rx_s = '0;
         rn.fc_s = '0;
         rn.rx_q = 1'b0;
         rn.fc_q = `LRP_FC_RESET;
         rn.hold_off = 1'b0;
      end
   end

   // record link registers
   always_ff @(posedge link.rec_clk) begin
      rr <= rn;
   end

   // system side: configuration, record drain, playback buffer and divider
   always_comb begin
      sn = sr;
      fall = 1'b0;
      pop = 1'b0;
      push = 1'b0;
      // software configuration
      if (cfg_load) begin
         sn.mode_r = cfg_mode;
         sn.fc_r = cfg_flow_control_enable;
         sn.sel_r = cfg_play_clock_select;
      end
      sn.rx_on = (sn.mode_r == receive_mode);
      // drain the record buffer into the user output stage
      sn.wg1 = rr.wgray;
      sn.wg2 = sr.wg1;
      if (sr.out_v && rec_out_ready) begin
         sn.out_v = 1'b0;
      end
      if (!sn.out_v && sr.rgray != sr.wg2) begin
         sn.out_d = rr.mem[sr.rbin[AW-1:0]];
         sn.out_v = 1'b1;
         sn.rbin = sr.rbin + 1'b1;
      end
      sn.rgray = gray_of(sn.rbin);
      // receiver hold-off pin, counted once two stages agree
      sn.hs = {sr.hs[1:0], link.play_hold_off};
      if (sr.hs[1] == sr.hs[2]) begin
         sn.hold_q = sr.hs[2];
      end
      // playback clock divider; outputs move on the falling half only
      if (sr.div >= lrp_play_half(sr.sel_r) - 8'h01) begin
         sn.div = 8'h00;
         sn.pclk = ~sr.pclk;
         fall = sr.pclk;
      end else begin
         sn.div = sr.div + 8'h01;
      end
      if (fall) begin
         if (sr.mode_r == transmit_mode && sr.pcnt != 2'h0 && !(sr.fc_r && sr.hold_q)) begin
            sn.pd = sr.pbuf[sr.prd];
            sn.pv = 1'b1;
            sn.prd = ~sr.prd;
            pop = 1'b1;
         end else begin
            sn.pv = 1'b0;
         end
      end
      // two-entry buffer fed by the user side
      push = play_in_valid && sr.in_ready;
      if (push) begin
         sn.pbuf[sr.pwr] = play_in_data;
         sn.pwr = ~sr.pwr;
      end
      sn.pcnt = sr.pcnt + {1'b0, push} - {1'b0, pop};
      sn.in_ready = (sn.pcnt != 2'h2) && (sn.mode_r == transmit_mode);
      sn.rst_seen = 1'b0;
      if (reset) begin
         sn = '0;
         sn.pbuf = sr.pbuf;
         sn.fc_r = `LRP_FC_RESET;
         sn.sel_r = `LRP_PLAY_CLK_RESET;
         // keep the playback clock running so the far end can reset
         if (sr.rst_seen) begin
            sn.pclk = ~sr.pclk;
         end else begin
            sn.pclk = 1'b0;
         end
         sn.rst_seen = 1'b1;
      end
   end

   // system registers
   always_ff @(posedge clk_sys) begin
      sr <= sn;
   end

   // outputs straight from registers
   assign link.rec_hold_off = rr.hold_off;
   assign link.play_clk = sr.pclk;
   assign link.play_data = sr.pd;
   assign link.play_word_valid = sr.pv;
   assign rec_out_data = sr.out_d;
   assign rec_out_valid = sr.out_v;
   assign play_in_ready = sr.in_ready;
   assign mode_status = sr.mode_r;
   assign flow_control_status = sr.fc_r;
endmodule
`default_nettype wire

/* File: lrp_far.sv */
// far end: data source on the record link, receiver on the playback link
`timescale 1ns/1ps
`default_nettype none
`include "lrp_consts.svh"
module lrp_far #(
   parameter int REC_HALF = `LRP_REC_HALF,
   parameter int SINK_DEPTH = `LRP_SINK_DEPTH,
   parameter int SINK_HOLD = `LRP_SINK_HOLD
) (
   input wire logic clk_sys,
   input wire logic reset,
   lrp_if.far link,
   input wire logic [`LRP_DATA_W-1:0] src_data,
   input wire logic src_valid,
   output logic src_ready,
   output logic [`LRP_DATA_W-1:0] sink_data,
   output logic sink_valid,
   input wire logic sink_ready
);
   import lrp_pkg::*;

   localparam int DW = `LRP_DATA_W;
   localparam int AW = $clog2(SINK_DEPTH);

   // divider and receive buffer limits
   if (REC_HALF < 1 || REC_HALF > 255 || SINK_DEPTH != (1 << AW)
       || SINK_HOLD < 1 || SINK_HOLD >= SINK_DEPTH) begin : g_bad_param
      $error("far end parameters out of range");
   end

   typedef logic [AW:0] lrp_fptr_t;

   localparam logic [7:0] HALF_M1 = 8'(REC_HALF - 1);
   localparam lrp_fptr_t HOLD_LEVEL = lrp_fptr_t'(SINK_HOLD);

   // state clocked by the playback clock
   typedef struct packed {
      logic [SINK_DEPTH-1:0][DW-1:0] mem;
      lrp_fptr_t wbin;
      lrp_fptr_t wgray;
      lrp_fptr_t rg1;
      lrp_fptr_t rg2;
      logic rs1;
      logic rs2;
   } lrp_fplay_st_t;

   // state clocked by the system clock
   typedef struct packed {
      logic [7:0] div;
      logic rclk;
      logic rst_seen;
      logic [DW-1:0] rd;
      logic rv;
      logic pend_v;
      logic [DW-1:0] pend_d;
      logic src_rdy;
      logic [2:0] hs;
      logic held;
      lrp_fptr_t wg1;
      lrp_fptr_t wg2;
      lrp_fptr_t rbin;
      lrp_fptr_t rgray;
      logic sk_v;
      logic [DW-1:0] sk_d;
      logic hold_out;
   } lrp_fsys_st_t;

   lrp_fplay_st_t pr;
   lrp_fplay_st_t pn;
   lrp_fsys_st_t sr;
   lrp_fsys_st_t sn;
   lrp_fptr_t fill;
   lrp_fptr_t used;
   logic fall;

   function automatic lrp_fptr_t gray_of(input lrp_fptr_t b);
      return b ^ (b >> 1);
   endfunction

   function automatic lrp_fptr_t bin_of(input lrp_fptr_t g);
      lrp_fptr_t b;
      b = g;
      for (int i = AW - 1; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction

   // playback link side: capture valid words at the rising edge
   always_comb begin
      pn = pr;
      pn.rs1 = reset;
      pn.rs2 = pr.rs1;
      pn.rg1 = sr.rgray;
      pn.rg2 = pr.rg1;
      fill = pr.wbin - bin_of(pr.rg2);
      if (link.play_word_valid && !fill[AW]) begin
         pn.mem[pr.wbin[AW-1:0]] = link.play_data;
         pn.wbin = pr.wbin + 1'b1;
      end
      pn.wgray = gray_of(pn.wbin);
      if (pr.rs2) begin
         pn.wbin = '0;
         pn.wgray = '0;
      end
   end

   // playback link registers
   always_ff @(posedge link.play_clk) begin
      pr <= pn;
   end

   // system side: record clock divider, source stage, sink drain
   always_comb begin
      sn = sr;
      fall = 1'b0;
      sn.hs = {sr.hs[1:0], link.rec_hold_off};
      if (sr.hs[1] == sr.hs[2]) begin
         sn.held = sr.hs[2];
      end
      if (sr.div >= HALF_M1) begin
         sn.div = 8'h00;
         sn.rclk = ~sr.rclk;
         fall = sr.rclk;
      end else begin
         sn.div = sr.div + 8'h01;
      end
      // new word presented on the falling half, none while held off
      if (fall) begin
         if (sr.pend_v && !sr.held) begin
            sn.rd = sr.pend_d;
            sn.rv = 1'b1;
            sn.pend_v = 1'b0;
         end else begin
            sn.rv = 1'b0;
         end
      end
      if (src_valid && sr.src_rdy) begin
         sn.pend_v = 1'b1;
         sn.pend_d = src_data;
      end
      sn.src_rdy = !sn.pend_v;
      // drain received words and hold the device off when half full
      sn.wg1 = pr.wgray;
      sn.wg2 = sr.wg1;
      if (sr.sk_v && sink_ready) begin
         sn.sk_v = 1'b0;
      end
      if (!sn.sk_v && sr.rgray != sr.wg2) begin
         sn.sk_d = pr.mem[sr.rbin[AW-1:0]];
         sn.sk_v = 1'b1;
         sn.rbin = sr.rbin + 1'b1;
      end
      sn.rgray = gray_of(sn.rbin);
      used = bin_of(sr.wg2) - sn.rbin;
      sn.hold_out = (used >= HOLD_LEVEL);
      sn.rst_seen = 1'b0;
      if (reset) begin
         sn = '0;
         // keep the record clock running so the device end can reset
         if (sr.rst_seen) begin
            sn.rclk = ~sr.rclk;
         end else begin
            sn.rclk = 1'b0;
         end
         sn.rst_seen = 1'b1;
      end
   end

   // system registers
   always_ff @(posedge clk_sys) begin
      sr <= sn;
   end

   // outputs straight from registers
   assign link.rec_clk = sr.rclk;
   assign link.rec_data = sr.rd;
   assign link.rec_word_valid = sr.rv;
   assign link.play_hold_off = sr.hold_out;
   assign src_ready = sr.src_rdy;
   assign sink_data = sr.sk_d;
   assign sink_valid = sr.sk_v;
endmodule
`default_nettype wire

/* File: lrp_asserts.sv */
// concurrent checks on the link between the device end and the far end
`timescale 1ns/1ps
`default_nettype none
`include "lrp_consts.svh"
module lrp_asserts (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic rec_clk,
   input wire logic [`LRP_DATA_W-1:0] rec_data,
   input wire logic rec_word_valid,
   input wire logic rec_hold_off,
   input wire logic play_clk,
   input wire logic [`LRP_DATA_W-1:0] play_data,
   input wire logic play_word_valid,
   input wire logic play_hold_off,
   input wire logic flow_control_status
);
   logic [5:0] flow_off_cnt_r;

   // cycles since flow control was last seen on, saturating
   always_ff @(posedge clk_sys) begin
      if (reset || flow_control_status) begin
         flow_off_cnt_r <= 6'h00;
      end else if (flow_off_cnt_r != 6'h3F) begin
         flow_off_cnt_r <= flow_off_cnt_r + 6'h01;
      end
   end

   // far end told to back off for three link edges
   sequence s_src_told;
      rec_hold_off[*3];
   endsequence

   // receiver held long enough for the hold-off to cross and a word to finish
   sequence s_play_held;
      (flow_control_status && play_hold_off)[*8] ##1 (flow_control_status && play_hold_off)[*4];
   endsequence

   // link data and qualifiers only move with the falling half of their clock
   property p_rec_data_fall;
      @(posedge clk_sys) disable iff (reset) $changed(rec_data) |-> $fell(rec_clk);
   endproperty
   property p_rec_valid_fall;
      @(posedge clk_sys) disable iff (reset) $changed(rec_word_valid) |-> $fell(rec_clk);
   endproperty
   property p_play_data_fall;
      @(posedge clk_sys) disable iff (reset) $changed(play_data) |-> $fell(play_clk);
   endproperty
   property p_play_valid_fall;
      @(posedge clk_sys) disable iff (reset) $changed(play_word_valid) |-> $fell(play_clk);
   endproperty
   // hold-off is a record-clock register
   property p_hold_edge;
      @(posedge clk_sys) disable iff (reset) $changed(rec_hold_off) |-> $rose(rec_clk);
   endproperty
   property p_src_backoff;
      @(posedge rec_clk) disable iff (reset) s_src_told |-> !rec_word_valid;
   endproperty
   property p_play_hold;
      @(posedge clk_sys) disable iff (reset) s_play_held |-> !play_word_valid;
   endproperty
   property p_flow_off;
      @(posedge clk_sys) disable iff (reset) flow_off_cnt_r == 6'h3F |-> !rec_hold_off;
   endproperty

   a_rec_data_fall: assert property (p_rec_data_fall) else $error("rec data off edge");
   a_rec_valid_fall: assert property (p_rec_valid_fall) else $error("rec valid off edge");
   a_play_data_fall: assert property (p_play_data_fall) else $error("play data off edge");
   a_play_valid_fall: assert property (p_play_valid_fall) else $error("play valid off");
   a_hold_edge: assert property (p_hold_edge) else $error("hold-off off edge");
   a_src_backoff: assert property (p_src_backoff) else $error("source kept sending");
   a_play_hold: assert property (p_play_hold) else $error("played while held");
   a_flow_off: assert property (p_flow_off) else $error("hold-off with flow off");
endmodule
`default_nettype wire

/* File: lvds_record_playback_port_tb.sv */
// self-checking bench joining the device end and the far end across the link
`timescale 1ns/1ps
`default_nettype none
`include "lrp_consts.svh"
module lvds_record_playback_port_tb;
   import lrp_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic cfg_load = 1'b0;
   lrp_mode_t cfg_mode = mode_idle;
   logic cfg_fc = 1'b0;
   lrp_clk_sel_t cfg_sel = clk_sel_200;
   logic [15:0] rec_out_data;
   logic rec_out_valid;
   logic rec_out_ready = 1'b0;
   logic [15:0] play_in_data = 16'h0000;
   logic play_in_valid = 1'b0;
   logic play_in_ready;
   lrp_mode_t mode_status;
   logic flow_control_status;
   logic [15:0] src_data = 16'h0000;
   logic src_valid = 1'b0;
   logic src_ready;
   logic [15:0] sink_data;
   logic sink_valid;
   logic sink_ready = 1'b0;
   int miscompares = 0;
   int compares = 0;
   int p;
   // expected playback clock period in system cycles for each frequency choice, never faster
   int exp_per[10] = '{6, 4, 2, 2, 2, 2, 2, 2, 2, 2};
   logic [15:0] rec_wire_q[$];
   logic [15:0] play_wire_q[$];

   lrp_if link();
   lrp_dev u_lrp_dev (
      .clk_sys(clk_sys), .reset(reset), .link(link.dev), .cfg_load(cfg_load),
      .cfg_mode(cfg_mode), .cfg_flow_control_enable(cfg_fc), .cfg_play_clock_select(cfg_sel),
      .rec_out_data(rec_out_data), .rec_out_valid(rec_out_valid), .rec_out_ready(rec_out_ready),
      .play_in_data(play_in_data), .play_in_valid(play_in_valid), .play_in_ready(play_in_ready),
      .mode_status(mode_status), .flow_control_status(flow_control_status));
   lrp_far u_lrp_far (
      .clk_sys(clk_sys), .reset(reset), .link(link.far), .src_data(src_data),
      .src_valid(src_valid), .src_ready(src_ready), .sink_data(sink_data),
      .sink_valid(sink_valid), .sink_ready(sink_ready));
   lrp_asserts u_lrp_asserts (
      .clk_sys(clk_sys), .reset(reset), .rec_clk(link.rec_clk), .rec_data(link.rec_data),
      .rec_word_valid(link.rec_word_valid), .rec_hold_off(link.rec_hold_off),
      .play_clk(link.play_clk), .play_data(link.play_data),
      .play_word_valid(link.play_word_valid), .play_hold_off(link.play_hold_off),
      .flow_control_status(flow_control_status));

   // 100 MHz system clock
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // words as the receiving end of each link latches them
   always @(posedge link.rec_clk) begin
      if (link.rec_word_valid === 1'b1) rec_wire_q.push_back(link.rec_data);
   end
   always @(posedge link.play_clk) begin
      if (link.play_word_valid === 1'b1) play_wire_q.push_back(link.play_data);
   end

   task automatic fail(input string m);
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_word({15'h0000, got}, {15'h0000, exp});
   endtask

   // inputs move 1 ns after the edge
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   task automatic cfg(input lrp_mode_t m, input logic fc, input lrp_clk_sel_t s);
      step(1);
      cfg_mode = m;
      cfg_fc = fc;
      cfg_sel = s;
      cfg_load = 1'b1;
      step(1);
      cfg_load = 1'b0;
      step(40);
   endtask

   // one word into the far source or the device playback side
   task automatic put(input bit to_play, input logic [15:0] w);
      int k = 0;
      step(1);
      if (to_play) begin
         play_in_data = w;
         play_in_valid = 1'b1;
      end else begin
         src_data = w;
         src_valid = 1'b1;
      end
      do begin
         @(posedge clk_sys);
         k++;
      end while ((to_play ? play_in_ready : src_ready) !== 1'b1 && k < 4000);
      #1;
      play_in_valid = 1'b0;
      src_valid = 1'b0;
      if (k >= 4000) fail("put stalled");
   endtask

   // one word out of the device record side or the far sink
   task automatic get(input bit from_sink, input logic [15:0] exp);
      int k = 0;
      step(1);
      if (from_sink) sink_ready = 1'b1;
      else rec_out_ready = 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while ((from_sink ? sink_valid : rec_out_valid) !== 1'b1 && k < 4000);
      check_word(from_sink ? sink_data : rec_out_data, exp);
      if (k >= 4000) fail("get stalled");
      #1;
      sink_ready = 1'b0;
      rec_out_ready = 1'b0;
   endtask

   // playback clock period in system cycles, rise to rise
   task automatic clk_period(output int n);
      do @(posedge clk_sys); while (link.play_clk !== 1'b0);
      do @(posedge clk_sys); while (link.play_clk !== 1'b1);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (link.play_clk !== 1'b0);
      do begin
         @(posedge clk_sys);
         n++;
      end while (link.play_clk !== 1'b1);
   endtask

   function automatic logic [15:0] pat(input int i);
      return 16'(16'h8000 >> (i % 16)) ^ 16'(i * 16'h0101);
   endfunction

   task automatic close_out();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // cuts a hang short
   initial begin
      repeat (60000) @(posedge clk_sys);
      fail("watchdog");
      close_out();
   end

   // main sequence
   initial begin
      step(12);
      reset = 1'b0;
      step(2);
      check_word(16'(mode_status), 16'(mode_idle));
      check_bit(flow_control_status, 1'b0);
      check_bit(play_in_ready, 1'b0);
      check_bit(link.rec_hold_off, 1'b0);
      clk_period(p);
      check_word(16'(p), 16'h0002);
      put(1'b0, 16'hDEAD);
      step(60);
      check_bit(rec_out_valid, 1'b0);
      cfg(receive_mode, 1'b0, clk_sel_200);
      rec_wire_q.delete();
      check_bit(play_in_ready, 1'b0);
      fork
         for (int i = 0; i < 8; i++) put(1'b0, pat(i));
         for (int i = 0; i < 8; i++) get(1'b0, pat(i));
      join
      check_bit(link.rec_hold_off, 1'b0);
      check_word(16'(rec_wire_q.size()), 16'h0008);
      for (int i = 0; i < 8; i++) check_word(rec_wire_q[i], pat(i));
      cfg(receive_mode, 1'b1, clk_sel_200);
      check_word(16'(mode_status), 16'(receive_mode));
      check_bit(flow_control_status, 1'b1);
      rec_wire_q.delete();
      fork
         for (int i = 0; i < 40; i++) put(1'b0, pat(i + 8));
      join_none
      step(1500);
      check_bit(link.rec_hold_off, 1'b1);
      check_bit(rec_wire_q.size() <= `LRP_REC_DEPTH, 1'b1);
      for (int i = 0; i < 40; i++) get(1'b0, pat(i + 8));
      wait fork;
      for (int s = 0; s < 10; s++) begin
         cfg(transmit_mode, 1'b1, lrp_clk_sel_t'(s));
         clk_period(p);
         check_word(16'(p), 16'(exp_per[s]));
         play_wire_q.delete();
         fork
            begin put(1'b1, pat(s)); put(1'b1, pat(s + 1)); end
            begin get(1'b1, pat(s)); get(1'b1, pat(s + 1)); end
         join
         check_word(play_wire_q[0], pat(s));
      end
      play_wire_q.delete();
      fork
         for (int i = 0; i < 24; i++) put(1'b1, pat(i + 50));
      join_none
      step(600);
      check_bit(link.play_hold_off, 1'b1);
      check_bit(play_wire_q.size() <= `LRP_SINK_DEPTH, 1'b1);
      for (int i = 0; i < 24; i++) get(1'b1, pat(i + 50));
      wait fork;
      cfg(transmit_mode, 1'b0, clk_sel_200);
      play_wire_q.delete();
      for (int i = 0; i < 24; i++) put(1'b1, pat(i));
      step(100);
      check_word(16'(play_wire_q.size()), 16'h0018);
      close_out();
   end
endmodule
`default_nettype wire
